/* File: src/scl_top.sv */
/*
  Supply crowbar watchdog, power button pulser, strap capture, LED
  controller and an AHB-Lite slave holding the configuration registers.
  Assumes one 50 MHz standby clock; pins are synchronised here.
*/
// The AHB-Lite slave port is this design's own decision.
`include "scl_defs.svh"
module scl_top
  import scl_pkg::*;
#(
  parameter logic [26:0] CB0_CYC = 27'(`SCL_MS2CYC(`SCL_CB0_MS)),
  parameter logic [26:0] CB1_CYC = 27'(`SCL_MS2CYC(`SCL_CB1_MS)),
  parameter logic [26:0] CB2_CYC = 27'(`SCL_MS2CYC(`SCL_CB2_MS)),
  parameter logic [26:0] CB3_CYC = 27'(`SCL_MS2CYC(`SCL_CB3_MS)),
  parameter logic [26:0] PB_CYC = 27'(`SCL_MS2CYC(`SCL_PB_MS)),
  parameter logic [26:0] TICK_CYC = 27'(`SCL_US2CYC(`SCL_TICK_US)),
  parameter logic [7:0] CHIP_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] CHIP_REV = 8'h01 // arbitrary value
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // supply and acpi pins
  input wire logic supply_good_in,
  input wire logic main_supply_in,
  input wire logic sleep_s3_in,
  input wire logic sleep_s5_in,
  input wire logic power_button_in,
  input wire logic supply_led_strap0,
  input wire logic supply_led_strap1,
  output logic supply_on_out,
  output logic power_button_out,
  // leds
  output logic led1_out,
  output logic led1_oe,
  output logic led2_out,
  output logic led2_oe
);

  // led field code to level; codes 6 and 7 stay dark
  function automatic logic led_level(input logic [2:0] code,
                                     input logic [4:0] tk);
    case (code)
      3'h1: led_level = 1'b1;
      3'h2: led_level = tk[1];
      3'h3: led_level = tk[2];
      3'h4: led_level = tk[3];
      3'h5: led_level = tk[4];
      default: led_level = 1'b0;
    endcase
  endfunction : led_level

  logic [4:0] meta_ff, sync_ff;
  logic [1:0] strap_meta_ff, strap_ff;
  logic strap_done_ff, psc_en_ff, led2_sel_ff;
  logic [1:0] fill_ff;
  logic [7:0] cf_ff [0:5];
  logic [7:0] shadow_ff, pinf_ff, lmode_ff, lstate_ff, pwr_ff;
  logic cbflag_ff, softoff_ff;
  scl_bus_t bus_ff;
  logic [5:0] idx_ff;
  logic [26:0] cb_cnt_ff, pb_cnt_ff, tick_cnt_ff;
  logic [4:0] tick_ff;
  logic crowbar_ff, forced_off_ff, legacy_on_ff, btn_prev_ff;
  logic [26:0] cb_lim;
  logic good, main_ok, s3_on, s5_sleep, btn;
  logic wr_go, crowbar_hit, pb_start, pb_end, pwr_wr;
  logic [7:0] wdat, rd_val;
  scl_led_mode_t lmode;
  logic lvl1, lvl2;

  assign good = sync_ff[0];
  assign main_ok = sync_ff[1];
  assign s3_on = sync_ff[2];
  assign s5_sleep = ~sync_ff[3];
  assign btn = sync_ff[4];
  assign wdat = hwdata[7:0];
  assign wr_go = (bus_ff == SCL_BUS_WR);
  assign pwr_wr = wr_go && (idx_ff == `SCL_IDX_PWR);

  // two flops on every supply, sleep, button and strap pin; only the second stage is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= 5'h00;
      sync_ff <= 5'h00;
      strap_meta_ff <= 2'h0;
      strap_ff <= 2'h0;
    end else if (clk_en) begin
      meta_ff <= {power_button_in, sleep_s5_in, sleep_s3_in,
                  main_supply_in, supply_good_in};
      sync_ff <= meta_ff;
      strap_meta_ff <= {supply_led_strap1, supply_led_strap0};
      strap_ff <= strap_meta_ff;
    end
  end

  // straps latched once after release; two edges first, else the pipeline
  // would still hold its reset zeros instead of the pin levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_ff <= 1'b0;
      psc_en_ff <= 1'b0;
      led2_sel_ff <= 1'b0;
      fill_ff <= 2'h0;
    end else if (clk_en) begin
      if (fill_ff != 2'h2) begin
        fill_ff <= fill_ff + 2'h1;
      end else if (!strap_done_ff) begin
        strap_done_ff <= 1'b1;
        psc_en_ff <= (strap_ff == 2'h0) || (strap_ff == 2'h3);
        led2_sel_ff <= strap_ff[1];
      end
    end
  end

  // ahb-lite: writes take no wait, reads one wait so data is current
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff <= SCL_BUS_IDLE;
      idx_ff <= 6'h00;
      hreadyout <= 1'b1;
    end else if (clk_en) begin
      if (hsel && hready && htrans[1]) begin
        idx_ff <= haddr[7:2];
        bus_ff <= hwrite ? SCL_BUS_WR : SCL_BUS_RD;
        hreadyout <= hwrite;
      end else begin
        bus_ff <= SCL_BUS_IDLE;
        hreadyout <= 1'b1;
      end
    end
  end

  // read mux; unmapped and reserved indexes read zero
  always_comb begin
    rd_val = 8'h00;
    case (idx_ff)
      `SCL_IDX_ID: rd_val = CHIP_ID;
      `SCL_IDX_CF1: rd_val = cf_ff[0];
      `SCL_IDX_CF2: rd_val = cf_ff[1];
      `SCL_IDX_CF3: rd_val = cf_ff[2];
      `SCL_IDX_CF4: rd_val = cf_ff[3];
      `SCL_IDX_CF5: rd_val = cf_ff[4];
      `SCL_IDX_SHADOW: rd_val = shadow_ff;
      `SCL_IDX_REV: rd_val = CHIP_REV;
      `SCL_IDX_CF8: rd_val = cf_ff[5];
      `SCL_IDX_PINF: rd_val = pinf_ff;
      `SCL_IDX_LMODE: rd_val = lmode_ff;
      `SCL_IDX_LSTATE: rd_val = lstate_ff;
      `SCL_IDX_PWR: rd_val = {pwr_ff[7:6], cbflag_ff, pwr_ff[4:2], 1'b0,
                              pwr_ff[0]};
      default: rd_val = 8'h00;
    endcase
  end

  // read data and an always-okay response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hresp <= 1'b0;
      if (bus_ff == SCL_BUS_RD) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  // plain configuration registers; 2Eh and unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 6; i++) begin
        cf_ff[i] <= `SCL_RST_REG;
      end
      shadow_ff <= `SCL_RST_REG;
      pinf_ff <= `SCL_RST_REG;
      lmode_ff <= `SCL_RST_REG;
      lstate_ff <= `SCL_RST_REG;
      pwr_ff <= `SCL_RST_REG;
    end else if (clk_en && wr_go) begin
      case (idx_ff)
        `SCL_IDX_CF1: cf_ff[0] <= wdat;
        `SCL_IDX_CF2: cf_ff[1] <= wdat;
        `SCL_IDX_CF3: cf_ff[2] <= wdat;
        `SCL_IDX_CF4: cf_ff[3] <= wdat;
        `SCL_IDX_CF5: cf_ff[4] <= wdat;
        `SCL_IDX_REV: shadow_ff <= wdat;
        `SCL_IDX_CF8: cf_ff[5] <= wdat;
        `SCL_IDX_PINF: pinf_ff <= wdat;
        `SCL_IDX_LMODE: lmode_ff <= wdat;
        `SCL_IDX_LSTATE: lstate_ff <= wdat;
        `SCL_IDX_PWR: pwr_ff <= wdat;
        default: ;
      endcase
    end
  end

  // crowbar flag: a new crowbar beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cbflag_ff <= 1'b0;
    end else if (clk_en) begin
      if (crowbar_hit) begin
        cbflag_ff <= 1'b1;
      end else if (pwr_wr && wdat[`SCL_PWR_CBFLAG]) begin
        cbflag_ff <= 1'b0;
      end
    end
  end

  // soft off is a one-shot command, it never reads back as one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      softoff_ff <= 1'b0;
    end else if (clk_en) begin
      softoff_ff <= pwr_wr && wdat[`SCL_PWR_SOFTOFF];
    end
  end

  // crowbar timeout select
  always_comb begin
    case (pwr_ff[`SCL_PWR_CB_HI:`SCL_PWR_CB_LO])
      2'h0: cb_lim = CB0_CYC;
      2'h1: cb_lim = CB1_CYC;
      2'h2: cb_lim = CB2_CYC;
      default: cb_lim = CB3_CYC;
    endcase
  end

  assign crowbar_hit = supply_on_out && !good && (cb_cnt_ff >= cb_lim - 27'h1);

  // crowbar timer runs only while supply-on waits for a dead supply
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cb_cnt_ff <= 27'h0;
    end else if (clk_en) begin
      if (!supply_on_out || good || crowbar_hit) begin
        cb_cnt_ff <= 27'h0;
      end else begin
        cb_cnt_ff <= cb_cnt_ff + 27'h1;
      end
    end
  end

  // button pulse: from a button press or from a crowbar
  assign pb_start = (btn && !btn_prev_ff) || crowbar_hit;
  assign pb_end = power_button_out && (pb_cnt_ff == PB_CYC - 27'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_prev_ff <= 1'b0;
      pb_cnt_ff <= 27'h0;
      power_button_out <= 1'b0;
    end else if (clk_en) begin
      btn_prev_ff <= btn;
      if (pb_end) begin
        power_button_out <= 1'b0;
        pb_cnt_ff <= 27'h0;
      end else if (power_button_out) begin
        pb_cnt_ff <= pb_cnt_ff + 27'h1;
      end else if (pb_start && psc_en_ff) begin
        power_button_out <= 1'b1;
      end
    end
  end

  // crowbar_ff marks a sync pulse until it ends, so that end never toggles
  // the legacy state back on; forced off is kept until the controller drops s3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crowbar_ff <= 1'b0;
      forced_off_ff <= 1'b0;
    end else if (clk_en) begin
      if (crowbar_hit) begin
        crowbar_ff <= 1'b1;
      end else if (pb_end) begin
        crowbar_ff <= 1'b0;
      end
      if (crowbar_hit) begin
        forced_off_ff <= 1'b1;
      end else if (!s3_on) begin
        forced_off_ff <= 1'b0;
      end
    end
  end

  // legacy on/off: button pulse end toggles, soft off or crowbar go off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      legacy_on_ff <= 1'b0;
    end else if (clk_en) begin
      if (crowbar_hit || softoff_ff) begin
        legacy_on_ff <= 1'b0;
      end else if (pb_end && !crowbar_ff) begin
        legacy_on_ff <= !legacy_on_ff;
      end
    end
  end

  // supply-on drive; inactive whenever the straps disable control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_on_out <= 1'b0;
    end else if (clk_en) begin
      if (!psc_en_ff || crowbar_hit) begin
        supply_on_out <= 1'b0;
      end else if (pwr_ff[`SCL_PWR_ACPI]) begin
        supply_on_out <= s3_on && !forced_off_ff;
      end else begin
        supply_on_out <= legacy_on_ff;
      end
    end
  end

  // blink time base: tick every 62.5 ms, bit 3 gives 1 hz
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= 27'h0;
      tick_ff <= 5'h00;
    end else if (clk_en) begin
      if (tick_cnt_ff == TICK_CYC - 27'h1) begin
        tick_cnt_ff <= 27'h0;
        tick_ff <= tick_ff + 5'h01;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 27'h1;
      end
    end
  end

  // led mode decode
  always_comb begin
    case (lmode_ff[`SCL_LMODE_HI:`SCL_LMODE_LO])
      2'h1: lmode = SCL_LED_HW1;
      2'h2: lmode = SCL_LED_HW2;
      default: lmode = SCL_LED_SW;
    endcase
  end

  // led levels by mode and system state; strap wait stands for reset
  always_comb begin
    lvl1 = 1'b0;
    lvl2 = 1'b0;
    case (lmode)
      SCL_LED_HW1: begin
        lvl1 = strap_done_ff && led_level(lstate_ff[2:0], tick_ff);
        lvl2 = (main_ok && strap_done_ff) ? led_level(lstate_ff[5:3], tick_ff)
                                          : tick_ff[3];
      end
      SCL_LED_HW2: begin
        if (pwr_ff[`SCL_PWR_ACPI] ? (s5_sleep && lstate_ff[`SCL_LST_S5OK] && psc_en_ff)
                                  : main_ok) begin
          lvl1 = led_level(lstate_ff[2:0], tick_ff);
          lvl2 = led_level(lstate_ff[5:3], tick_ff);
        end
      end
      default: begin
        if (main_ok) begin
          lvl1 = led_level(lstate_ff[2:0], tick_ff);
          lvl2 = led_level(lstate_ff[5:3], tick_ff);
        end
      end
    endcase
  end

  // led pins; an unselected pin is released and parks inactive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led1_out <= 1'b0;
      led2_out <= 1'b0;
      led1_oe <= 1'b0;
      led2_oe <= 1'b0;
    end else if (clk_en) begin
      led1_oe <= pinf_ff[2:1] != 2'h0;
      led2_oe <= pinf_ff[3] && led2_sel_ff;
      led1_out <= (pinf_ff[2:1] != 2'h0 && lvl1) ^ pwr_ff[`SCL_PWR_POL];
      led2_out <= (pinf_ff[3] && led2_sel_ff && lvl2) ^ pwr_ff[`SCL_PWR_POL];
    end
  end

endmodule : scl_top

/* File: src/scl_defs.svh */
/*
  Constants of the supply crowbar and LED control block: register
  indexes, field positions, reset values and timing figures.
  Assumes a 50 MHz standby clock; included by scl_top.
*/
// What this block does
// - Supply on while supply dead starts a crowbar timer; terminal count flags crowbar.
// - Crowbar drops supply-on and steers the ACPI power state to OFF.
// - Crowbar timeout 0.5 to 2.25 s, chosen by power control bits 4-3.
// - Up to two LED outputs, each present only when pin function bits select it.
// - Power control bit 7 sets the polarity of both LED outputs.
// - LED mode bits 3-2: 01 hardware mode one, 10 hardware mode two, else software.
// - LED state bits 2-0 drive LED1, bits 5-3 drive LED2: on, off or blink.
// - Software mode: LEDs follow fields with main supply, off without it.
// - Mode one: LED1 off in reset; LED2 blinks 1 Hz in standby-only power off.
// - Mode two: in ACPI, LEDs software only in S5 with bit 6 and control on; in legacy, with main supply.
// - Strap inputs are sampled once, right after standby power-up reset.
// - Straps 00 control on; 01 neither; 10 LED2 only; 11 both.
// - Write-one-to-clear bits clear on 1 and keep on 0.
// - One index reads one register while writes land in another register.
// - Registers live at indexes 20h-2Eh; 2Eh is reserved and inert.
// - Legacy crowbar returns the controller OFF and pulses the button output.
// - ACPI crowbar forces supply-on inactive and pulses the button output.
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH
// register indexes; byte address is four times the index
`define SCL_IDX_ID 6'h20
`define SCL_IDX_CF1 6'h21
`define SCL_IDX_CF2 6'h22
`define SCL_IDX_CF3 6'h23
`define SCL_IDX_CF4 6'h24
`define SCL_IDX_CF5 6'h25
`define SCL_IDX_SHADOW 6'h26
`define SCL_IDX_REV 6'h27
`define SCL_IDX_CF8 6'h28
`define SCL_IDX_PINF 6'h2A
`define SCL_IDX_LMODE 6'h2B
`define SCL_IDX_LSTATE 6'h2C
`define SCL_IDX_PWR 6'h2D
`define SCL_IDX_RSVD 6'h2E
// field positions
`define SCL_PWR_ACPI 0
`define SCL_PWR_SOFTOFF 1
`define SCL_PWR_CB_LO 3
`define SCL_PWR_CB_HI 4
`define SCL_PWR_CBFLAG 5
`define SCL_PWR_POL 7
`define SCL_LST_S5OK 6
`define SCL_LMODE_LO 2
`define SCL_LMODE_HI 3
// reset values
`define SCL_RST_REG 8'h00
// timing, in milliseconds and microseconds, and derived cycle counts at 50 MHz
`define SCL_CLK_KHZ 50000
`define SCL_CB0_MS 500
`define SCL_CB1_MS 1000
`define SCL_CB2_MS 1500
`define SCL_CB3_MS 2250
`define SCL_PB_MS 100
`define SCL_TICK_US 62500
`define SCL_MS2CYC(ms) ((ms) * `SCL_CLK_KHZ)
`define SCL_US2CYC(us) ((us) * (`SCL_CLK_KHZ / 1000))
`endif

/* File: src/scl_pkg.sv */
/*
  Types of the supply crowbar and LED control block.
  Assumes nothing beyond the defs header.
*/
package scl_pkg;
  typedef enum logic [1:0] {
    SCL_LED_SW,
    SCL_LED_HW1,
    SCL_LED_HW2
  } scl_led_mode_t;
  typedef enum logic [1:0] {
    SCL_BUS_IDLE,
    SCL_BUS_RD,
    SCL_BUS_WR
  } scl_bus_t;
endpackage : scl_pkg

/* File: sim/scl_top_monitor.sv */
/*
  Port checks for scl_top.
  Assumes clk_en low only while bus and supply pins are quiet, and
  straps steady once reset is released.
*/
module scl_top_monitor #(
  parameter logic [26:0] PB_CYC = 27'd20,
  parameter logic [26:0] CB3_CYC = 27'd900
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // supply pins, straps and the second led enable
  input wire logic supply_good_in,
  input wire logic supply_led_strap0,
  input wire logic supply_led_strap1,
  input wire logic supply_on_out,
  input wire logic power_button_out,
  input wire logic led2_oe
);
  logic [26:0] pb_cnt_ff;
  logic [26:0] cb_cnt_ff;
  logic [1:0] strap_ff;
  logic take;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign take = hsel && hready && htrans[1];
  // strap levels sampled while reset is held; the block latches them just after release
  always_ff @(posedge hclk) begin
    if (!hresetn)
      strap_ff <= {supply_led_strap1, supply_led_strap0};
  end
  // width of the running button pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pb_cnt_ff <= '0;
    else
      pb_cnt_ff <= power_button_out ? pb_cnt_ff + 27'd1 : 27'd0;
  end
  // supply requested but silent; a counter, as the wait is too long to unroll
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cb_cnt_ff <= '0;
    else
      cb_cnt_ff <= (supply_on_out && !supply_good_in) ? cb_cnt_ff + 27'd1 : 27'd0;
  end
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rd_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  rd_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  pb_width_a: assert property ($fell(power_button_out) |-> pb_cnt_ff == PB_CYC)
    else $error("button pulse width wrong");
  cb_bound_a: assert property (cb_cnt_ff <= CB3_CYC + 27'd8)
    else $error("crowbar never fired");
  strap_gate_a: assert property (strap_ff[0] != strap_ff[1] |-> !supply_on_out && !power_button_out)
    else $error("supply control not gated");
  led2_sel_a: assert property (led2_oe |-> strap_ff[1])
    else $error("second led without strap");
  rst_quiet_a: assert property ($rose(hresetn) |-> !supply_on_out && !power_button_out && hreadyout)
    else $error("outputs busy after reset");
  cover property (take && !hwrite);
  cover property ($rose(power_button_out) && !supply_on_out);
  cover property ($rose(led2_oe));
endmodule : scl_top_monitor

bind scl_top scl_top_monitor #(.PB_CYC(PB_CYC), .CB3_CYC(CB3_CYC)) mon (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .supply_good_in, .supply_led_strap0, .supply_led_strap1,
  .supply_on_out, .power_button_out, .led2_oe);

/* File: sim/scl_partner.sv */
/*
  Model of the power supply and the acpi controller.
  Assumes the bench raises dead to make the supply never answer.
*/
module scl_partner (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // from the block
  input wire logic supply_on_out,
  input wire logic power_button_out,
  // fault control
  input wire logic dead,
  // to the block
  output logic supply_good_in,
  output logic sleep_s3_in
);
  logic [2:0] dly_ff;
  logic pb_ff;
  // supply comes good a few cycles after being switched on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_ff <= '0;
      supply_good_in <= 1'b0;
    end else begin
      dly_ff <= {dly_ff[1:0], supply_on_out && !dead};
      supply_good_in <= &dly_ff;
    end
  end
  // controller flips its sleep state on each button pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pb_ff <= 1'b0;
      sleep_s3_in <= 1'b0;
    end else begin
      pb_ff <= power_button_out;
      if (power_button_out && !pb_ff)
        sleep_s3_in <= !sleep_s3_in;
    end
  end
endmodule : scl_partner

/* File: sim/scl_top_tb.sv */
/*
  Self-checking bench for scl_top with the supply model.
  Assumes shortened counts below; clk_en drops once, with the bus idle.
*/
module scl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] md, pw, st;
    logic mn, s5, l1, l2;
  } scl_row_t;
  localparam logic [7:0] ID_VAL = 8'hA5; // arbitrary value
  localparam logic [7:0] REV_VAL = 8'h3C; // arbitrary value
  localparam int CBC [4] = '{200, 400, 600, 900};
  localparam logic [5:0] RWI [6] = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h28};
  // mode, power, state, main, s5, led1, led2
  localparam scl_row_t LT [9] = '{
    '{8'h00, 8'h00, 8'h09, 1'b1, 1'b1, 1'b1, 1'b1},
    '{8'h00, 8'h00, 8'h31, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'h38, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h00, 8'h80, 8'h01, 1'b1, 1'b1, 1'b0, 1'b1},
    '{8'h00, 8'h00, 8'h09, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h08, 8'h01, 8'h49, 1'b1, 1'b0, 1'b1, 1'b1},
    '{8'h08, 8'h01, 8'h09, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h08, 8'h01, 8'h49, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h08, 8'h00, 8'h49, 1'b0, 1'b1, 1'b0, 1'b0}};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic supply_good_in, sleep_s3_in, supply_on_out, power_button_out;
  logic main_supply_in = 1'b1;
  logic sleep_s5_in = 1'b1;
  logic power_button_in = 1'b0;
  logic supply_led_strap0 = 1'b0;
  logic supply_led_strap1 = 1'b0;
  logic led1_out, led1_oe, led2_out, led2_oe;
  logic dead = 1'b0;
  logic rd_dp = 1'b0;
  logic [31:0] rng = 32'h9813;
  logic [7:0] exp_q [$];
  int failures = 0;
  int tests_run = 0;
  // the one slave's ready is the bus ready
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  scl_top #(.CB0_CYC(27'd200), .CB1_CYC(27'd400), .CB2_CYC(27'd600), .CB3_CYC(27'd900),
    .PB_CYC(27'd20), .TICK_CYC(27'd4), .CHIP_ID(ID_VAL), .CHIP_REV(REV_VAL)) dut (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .supply_good_in, .main_supply_in, .sleep_s3_in, .sleep_s5_in,
    .power_button_in, .supply_led_strap0, .supply_led_strap1, .supply_on_out,
    .power_button_out, .led1_out, .led1_oe, .led2_out, .led2_oe);
  scl_partner peer (.hclk, .hresetn, .supply_on_out, .power_button_out, .dead,
    .supply_good_in, .sleep_s3_in);
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task tally_and_finish;
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task bail;
    failures++;
    tally_and_finish;
  endtask : bail
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task ticks(input int n);
    repeat (n) @(posedge hclk);
  endtask : ticks
  // ready is looked at just before the edge that samples it
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
      if (n > 64)
        bail;
    end while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask : wait_rdy
  // one single word transfer; for a read d is the expected byte
  task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, idx, 2'b00};
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    if (!wr) begin
      exp_q.push_back(d);
      rd_dp = 1'b1;
    end
    wait_rdy;
  endtask : bus
  task do_reset(input logic [1:0] s);
    @(posedge hclk);
    hresetn <= 1'b0;
    supply_led_strap0 <= s[0];
    supply_led_strap1 <= s[1];
    ticks(4);
    hresetn <= 1'b1;
    ticks(4);
  endtask : do_reset
  task pulse_btn;
    @(posedge hclk);
    power_button_in <= 1'b1;
    ticks(4);
    power_button_in <= 1'b0;
  endtask : pulse_btn
  // waits for supply (w=0) or button output (w=1) to reach v
  task wait_for(input logic w, input logic v, output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
      if (n > 3000)
        bail;
    end while ((w ? power_button_out : supply_on_out) !== v);
  endtask : wait_for
  // read data watcher takes the oldest note
  always @(negedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      rd_dp = 1'b0;
      cmp(hrdata, {24'h0, exp_q.pop_front()});
    end
  end
  initial begin
    #2000000;
    bail;
  end
  initial begin
    int n;
    logic [7:0] cfg;
    logic last;
    do_reset(2'b00);
    // map, identity, shadow and reserved places
    bus(1'b0, 6'h2D, 8'h00);
    bus(1'b1, 6'h20, 8'hFF);
    bus(1'b0, 6'h20, ID_VAL);
    bus(1'b1, 6'h2E, 8'h77);
    bus(1'b0, 6'h2E, 8'h00);
    bus(1'b0, 6'h3F, 8'h00);
    bus(1'b1, 6'h27, 8'h6C);
    bus(1'b0, 6'h27, REV_VAL);
    bus(1'b0, 6'h26, 8'h6C);
    foreach (RWI[i]) begin
      rng = xs(rng);
      bus(1'b1, RWI[i], {1'b0, rng[6:0]});
      bus(1'b0, RWI[i], {1'b0, rng[6:0]});
    end
    // strap decode; straps moved after capture must not count
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      bus(1'b1, 6'h2A, 8'h08);
      if (s == 0) begin
        supply_led_strap0 <= 1'b1;
        supply_led_strap1 <= 1'b1;
      end
      pulse_btn;
      ticks(40);
      @(negedge hclk);
      cmp(led2_oe, s[1]);
      cmp(supply_on_out, s[0] == s[1]);
      ticks(600);
      @(negedge hclk);
      cmp(supply_on_out, s[0] == s[1]);
      if (s == 3) begin
        // soft off command drops a legacy supply
        bus(1'b1, 6'h2D, 8'h02);
        ticks(4);
        @(negedge hclk);
        cmp(supply_on_out, 1'b0);
      end
    end
    // led modes, codes and polarity
    do_reset(2'b11);
    bus(1'b1, 6'h2A, 8'h0E);
    foreach (LT[i]) begin
      bus(1'b1, 6'h2B, LT[i].md);
      bus(1'b1, 6'h2D, LT[i].pw);
      bus(1'b1, 6'h2C, LT[i].st);
      main_supply_in <= LT[i].mn;
      sleep_s5_in <= LT[i].s5;
      ticks(8);
      @(negedge hclk);
      cmp({led1_oe, led2_oe}, 2'b11);
      cmp(led1_out, LT[i].l1);
      cmp(led2_out, LT[i].l2);
    end
    // a low enable freezes every flop; mode two legacy with main lights led1
    @(posedge hclk);
    clk_en <= !clk_en;
    main_supply_in <= 1'b1;
    ticks(8);
    @(negedge hclk);
    cmp(led1_out, 1'b0);
    @(posedge hclk);
    clk_en <= !clk_en;
    ticks(8);
    @(negedge hclk);
    cmp(led1_out, 1'b1);
    // mode one blink with standby only
    bus(1'b1, 6'h2B, 8'h04);
    bus(1'b1, 6'h2D, 8'h00);
    bus(1'b1, 6'h2C, 8'h01);
    main_supply_in <= 1'b0;
    ticks(8);
    @(negedge hclk);
    n = 0;
    last = led2_out;
    repeat (320) begin
      @(negedge hclk);
      if (led2_out !== last)
        n++;
      last = led2_out;
    end
    cmp(n >= 9 && n <= 11, 1'b1);
    cmp(led1_out, 1'b1);
    // crowbar for every timeout code, legacy and acpi in turn
    @(posedge hclk);
    main_supply_in <= 1'b1;
    dead <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      cfg = {3'b000, c[1:0], 2'b00, c[0]};
      bus(1'b1, 6'h2D, cfg);
      pulse_btn;
      wait_for(1'b0, 1'b1, n);
      wait_for(1'b0, 1'b0, n);
      cmp(n >= CBC[c] && n <= CBC[c] + 6, 1'b1);
      cmp(power_button_out, 1'b1);
      bus(1'b0, 6'h2D, cfg | 8'h20);
      bus(1'b1, 6'h2D, cfg | 8'h20);
      bus(1'b0, 6'h2D, cfg);
      wait_for(1'b1, 1'b0, n);
      ticks(4);
      @(negedge hclk);
      cmp(supply_on_out, 1'b0);
    end
    tally_and_finish;
  end
endmodule : scl_top_tb
